// file: logic/ncs_config_store.sv
// Configuration store and update control for a clock generator.
// Assumes a register access port decoded from the serial control
// port, a byte-wide store with request and acknowledge, and a buffer
// register bank read combinationally by address.
`timescale 1ns/100ps
module ncs_config_store
  import ncs_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_sclk,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  input  wire logic [11:0]  i_reg_addr,
  input  wire logic [7:0]   i_reg_wdata,
  output logic      [7:0]   o_reg_rdata,
  input  wire logic         i_boot_sel,
  input  wire logic         i_status_mon0,
  output logic              o_status_out_zero,
  output logic              o_input_loop_off,
  output logic              o_synth_loop_off,
  output logic              o_dist_off,
  output logic              o_apply_update,
  output logic              o_soft_reset,
  output ncs_nv_req_t       o_nv,
  input  wire logic         i_nv_ack,
  input  wire logic [7:0]   i_nv_rdata,
  input  wire logic         i_nv_err,
  output ncs_buf_req_t      o_buf,
  input  wire logic [7:0]   i_buf_rdata
);

  // Control registers.
  logic [2:0]        power_down_control;
  logic              status_out_zero_sel;
  logic              write_enable;
  logic              data_error;

  // Transfer engine state.
  ncs_eng_state_t    state;
  logic              dir_write;
  logic [SEG_IW-1:0] seg_idx;
  logic [6:0]        bytes_left;
  logic [NV_AW-1:0]  nv_addr;
  logic              engine_update;

  // Register decode and table read data.
  logic              wr_seg;
  logic [SEG_IW-1:0] host_seg_idx;
  logic [7:0]        host_seg_byte;
  logic [7:0]        eng_seg_byte;
  logic              busy;
  logic              start_store;
  logic              start_reload;
  logic              host_update;

  assign busy         = (state != ENG_IDLE);
  assign host_seg_idx = SEG_IW'(i_reg_addr - ADDR_SEG_FIRST);
  assign wr_seg       = i_reg_wr && (i_reg_addr >= ADDR_SEG_FIRST)
                        && (i_reg_addr <= ADDR_SEG_LAST);
  assign host_update  = i_reg_wr && (i_reg_addr == ADDR_APPLY_UPDATE)
                        && i_reg_wdata[BIT_APPLY_UPDATE];

  // Starts are taken only while idle; a protected store is dropped.
  assign start_store  = i_reg_wr && (i_reg_addr == ADDR_CONTROL_TWO)
                        && i_reg_wdata[BIT_NV_STORE_START]
                        && write_enable && !busy;
  assign start_reload = i_reg_wr && (i_reg_addr == ADDR_CONTROL_ONE)
                        && i_reg_wdata[BIT_SOFT_RELOAD]
                        && !i_boot_sel && !busy;

  ncs_seg_table #(
    .N (SEG_COUNT)
  ) u_seg_table (
    .i_core_clk  (i_core_clk),
    .i_rst_b     (i_rst_b),
    .i_wr        (wr_seg),
    .i_widx      (host_seg_idx),
    .i_wdata     (i_reg_wdata),
    .i_host_idx  (host_seg_idx),
    .i_eng_idx   (seg_idx),
    .o_host_byte (host_seg_byte),
    .o_eng_byte  (eng_seg_byte)
  );

  ncs_update_sync u_update (
    .i_core_clk   (i_core_clk),
    .i_rst_b      (i_rst_b),
    .i_sclk       (i_sclk),
    .i_host_req   (host_update),
    .i_engine_now (engine_update),
    .o_apply      (o_apply_update)
  );

  // Power-down bits; every block starts powered down.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      power_down_control <= POWER_DOWN_RESET;
    end else if (i_reg_wr && (i_reg_addr == ADDR_POWER_DOWN)) begin
      power_down_control <= i_reg_wdata[2:0];
    end
  end

  assign o_input_loop_off = power_down_control[BIT_INPUT_LOOP_OFF];
  assign o_synth_loop_off = power_down_control[BIT_SYNTH_LOOP_OFF];
  assign o_dist_off       = power_down_control[BIT_DIST_OFF];

  // Status pin select bit and store write enable.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      status_out_zero_sel  <= STATUS_OUT_ZERO_SEL_RESET;
      write_enable <= WRITE_ENABLE_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_STATUS_PIN_CTL) begin
        status_out_zero_sel <= i_reg_wdata[BIT_STATUS_OUT_ZERO_NV_SEL];
      end
      if (i_reg_addr == ADDR_CONTROL_ONE) begin
        write_enable <= i_reg_wdata[BIT_WRITE_ENABLE];
      end
    end
  end

  // Status output 0 shows the pending flag when selected.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_status_out_zero <= 1'b0;
    end else begin
      o_status_out_zero <= status_out_zero_sel ? busy : i_status_mon0;
    end
  end

  // Soft reset pulse accompanies the start of a reload.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= start_reload;
    end
  end

  // Transfer engine: walks the segment list, moving one byte at a time.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state      <= ENG_IDLE;
      dir_write  <= 1'b0;
      seg_idx    <= '0;
      bytes_left <= '0;
      nv_addr    <= '0;
    end else begin
      unique case (state)
        ENG_IDLE: begin
          if (start_store || start_reload) begin
            dir_write <= start_store;
            seg_idx   <= '0;
            nv_addr   <= '0;
            state     <= ENG_FETCH_CNT;
          end
        end
        ENG_FETCH_CNT: begin
          if (eng_seg_byte == SEG_OP_UPDATE) begin
            seg_idx <= seg_idx + SEG_IW'(1);
          end else if (eng_seg_byte[7]) begin
            state <= ENG_DONE;
          end else begin
            bytes_left <= eng_seg_byte[6:0];
            seg_idx    <= seg_idx + SEG_IW'(1);
            state      <= ENG_FETCH_HI;
          end
        end
        ENG_FETCH_HI: begin
          seg_idx <= seg_idx + SEG_IW'(1);
          state   <= ENG_FETCH_LO;
        end
        ENG_FETCH_LO: begin
          seg_idx <= seg_idx + SEG_IW'(1);
          state   <= ENG_MOVE;
        end
        ENG_MOVE: begin
          state <= ENG_WAIT;
        end
        ENG_WAIT: begin
          if (i_nv_ack) begin
            nv_addr <= nv_addr + NV_AW'(1);
            if (bytes_left == 7'h00) begin
              state <= ENG_FETCH_CNT;
            end else begin
              bytes_left <= bytes_left - 7'h01;
              state      <= ENG_MOVE;
            end
          end
        end
        ENG_DONE: begin
          state <= ENG_IDLE;
        end
      endcase
    end
  end

  // Update opcode pulse from the segment walk.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      engine_update <= 1'b0;
    end else begin
      engine_update <= (state == ENG_FETCH_CNT)
                       && (eng_seg_byte == SEG_OP_UPDATE);
    end
  end

  // Buffer address: loaded from the segment, stepped after each byte.
  // A reload steps it only after its write pulse, so the byte lands first.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_buf.addr <= '0;
    end else if (state == ENG_FETCH_HI) begin
      o_buf.addr <= {eng_seg_byte[3:0], o_buf.addr[7:0]};
    end else if (state == ENG_FETCH_LO) begin
      o_buf.addr <= {o_buf.addr[11:8], eng_seg_byte};
    end else if ((state == ENG_WAIT) && i_nv_ack && dir_write) begin
      o_buf.addr <= o_buf.addr + 12'h001;
    end else if (o_buf.we) begin
      o_buf.addr <= o_buf.addr + 12'h001;
    end
  end

  // Buffer write on a reload: one pulse per acknowledged store byte.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_buf.we   <= 1'b0;
      o_buf.data <= 8'h00;
    end else begin
      o_buf.we <= (state == ENG_WAIT) && i_nv_ack && !dir_write;
      if ((state == ENG_WAIT) && i_nv_ack) begin
        o_buf.data <= i_nv_rdata;
      end
    end
  end

  // Store request held from the move step until acknowledge.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_nv <= '0;
    end else if (state == ENG_MOVE) begin
      o_nv.req   <= 1'b1;
      o_nv.write <= dir_write;
      o_nv.addr  <= nv_addr;
      o_nv.data  <= i_buf_rdata;
    end else if (i_nv_ack) begin
      o_nv.req <= 1'b0;
    end
  end

  // Error flag: cleared at a taken start, set by a flagged byte.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      data_error <= 1'b0;
    end else if ((state == ENG_WAIT) && i_nv_ack && i_nv_err) begin
      data_error <= 1'b1;
    end else if (start_store || start_reload) begin
      data_error <= 1'b0;
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= 8'h00;
      if ((i_reg_addr >= ADDR_SEG_FIRST)
          && (i_reg_addr <= ADDR_SEG_LAST)) begin
        o_reg_rdata <= host_seg_byte;
      end
      unique case (i_reg_addr)
        ADDR_STATUS_PIN_CTL:
          o_reg_rdata[BIT_STATUS_OUT_ZERO_NV_SEL] <= status_out_zero_sel;
        ADDR_POWER_DOWN:
          o_reg_rdata[2:0] <= power_down_control;
        ADDR_XFER_STATUS:
          o_reg_rdata[BIT_XFER_PENDING] <= busy;
        ADDR_ERROR_READBACK:
          o_reg_rdata[BIT_DATA_ERROR] <= data_error;
        ADDR_CONTROL_ONE: begin
          o_reg_rdata[BIT_SOFT_RELOAD]  <= busy && !dir_write;
          o_reg_rdata[BIT_WRITE_ENABLE] <= write_enable;
        end
        ADDR_CONTROL_TWO:
          o_reg_rdata[BIT_NV_STORE_START] <= busy && dir_write;
        default: begin
        end
      endcase
    end
  end

endmodule

// file: shared/ncs_pkg.sv
// Package for the configuration store and update block.
// Holds the register map, field positions, reset values, segment
// table defaults and the carrier structs shared by the design files.
package ncs_pkg;

  // Register offsets in the serial port address space.
  localparam logic [11:0] ADDR_STATUS_PIN_CTL   = 12'h232;
  localparam logic [11:0] ADDR_POWER_DOWN       = 12'h233;
  localparam logic [11:0] ADDR_APPLY_UPDATE     = 12'h234;
  localparam logic [11:0] ADDR_SEG_FIRST        = 12'hA00;
  localparam logic [11:0] ADDR_SEG_LAST         = 12'hA16;
  localparam logic [11:0] ADDR_XFER_STATUS      = 12'hB00;
  localparam logic [11:0] ADDR_ERROR_READBACK   = 12'hB01;
  localparam logic [11:0] ADDR_CONTROL_ONE      = 12'hB02;
  localparam logic [11:0] ADDR_CONTROL_TWO      = 12'hB03;

  // Field positions.
  localparam int BIT_STATUS_OUT_ZERO_NV_SEL = 4;
  localparam int BIT_INPUT_LOOP_OFF = 2;
  localparam int BIT_SYNTH_LOOP_OFF = 1;
  localparam int BIT_DIST_OFF       = 0;
  localparam int BIT_APPLY_UPDATE   = 0;
  localparam int BIT_XFER_PENDING   = 0;
  localparam int BIT_DATA_ERROR     = 0;
  localparam int BIT_SOFT_RELOAD    = 1;
  localparam int BIT_WRITE_ENABLE   = 0;
  localparam int BIT_NV_STORE_START = 0;

  // Reset values.
  localparam logic [2:0] POWER_DOWN_RESET   = 3'h7;
  localparam logic       WRITE_ENABLE_RESET = 1'b0;
  localparam logic       STATUS_OUT_ZERO_SEL_RESET  = 1'b0;

  // Segment table geometry and operation codes.
  localparam int          SEG_COUNT     = 23;
  localparam int          SEG_IW        = 5;
  localparam logic [7:0]  SEG_OP_UPDATE = 8'h80;
  localparam logic [7:0]  SEG_OP_END    = 8'hFF;
  localparam int          NV_AW         = 11;

  // Default segment list: three 128-byte ranges, an update, then end.
  localparam logic [7:0] SEG_DEFAULT [SEG_COUNT] = '{
    8'h7F, 8'h00, 8'h00,
    8'h7F, 8'h01, 8'h00,
    8'h7F, 8'h02, 8'h00,
    8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  // Request towards the nonvolatile store.
  typedef struct packed {
    logic             req;
    logic             write;
    logic [NV_AW-1:0] addr;
    logic [7:0]       data;
  } ncs_nv_req_t;

  // Write port towards the buffer register bank.
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } ncs_buf_req_t;

  // Transfer engine states.
  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_FETCH_CNT,
    ENG_FETCH_HI,
    ENG_FETCH_LO,
    ENG_MOVE,
    ENG_WAIT,
    ENG_DONE
  } ncs_eng_state_t;

endpackage

// file: logic/ncs_seg_table.sv
// Segment table storage: one byte per entry, two read ports.
// Assumes a single core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module ncs_seg_table
  import ncs_pkg::*;
#(
  parameter int N = SEG_COUNT
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_wr,
  input  wire logic [SEG_IW-1:0] i_widx,
  input  wire logic [7:0]        i_wdata,
  input  wire logic [SEG_IW-1:0] i_host_idx,
  input  wire logic [SEG_IW-1:0] i_eng_idx,
  output logic      [7:0]        o_host_byte,
  output logic      [7:0]        o_eng_byte
);

  logic [7:0] seg_q [N];

  // Each entry resets to its default so a transfer covers the three default ranges.
  for (genvar g = 0; g < N; g++) begin : g_entry
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
        seg_q[g] <= SEG_DEFAULT[g];
      end else if (i_wr && (i_widx == SEG_IW'(g))) begin
        seg_q[g] <= i_wdata;
      end
    end
  end

  // Engine reads beyond the table return the end code so the walk stops.
  always_comb begin
    o_host_byte = (i_host_idx < SEG_IW'(N)) ? seg_q[i_host_idx] : 8'h00;
    o_eng_byte  = (i_eng_idx < SEG_IW'(N)) ? seg_q[i_eng_idx] : SEG_OP_END;
  end

endmodule

// file: logic/ncs_update_sync.sv
// Update launcher: turns an update request into one apply pulse.
// Assumes the serial clock is sampled as an ordinary synchronous input.
`timescale 1ns/100ps
module ncs_update_sync
  import ncs_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_sclk,
  input  wire logic i_host_req,
  input  wire logic i_engine_now,
  output logic      o_apply
);

  logic sclk_q;
  logic pending;
  logic sclk_rise;

  assign sclk_rise = i_sclk && !sclk_q;

  // Previous serial clock level for edge detection.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
    end
  end

  // A host request waits for the next serial clock rise, then clears.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pending <= 1'b0;
    end else if (i_host_req) begin
      pending <= 1'b1;
    end else if (sclk_rise) begin
      pending <= 1'b0;
    end
  end

  // The engine opcode applies at once; the serial clock may be idle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_apply <= 1'b0;
    end else begin
      o_apply <= (pending && sclk_rise) || i_engine_now;
    end
  end

endmodule

// file: verif/ncs_config_store_asserts.sv
// Checker for the configuration store block, watching its top ports.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module ncs_config_store_asserts
  import ncs_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_reg_wr,
  input wire logic [11:0] i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_boot_sel,
  input wire logic        i_status_mon0,
  input wire logic        o_status_out_zero,
  input wire logic        o_input_loop_off,
  input wire logic        o_synth_loop_off,
  input wire logic        o_dist_off,
  input wire logic        o_apply_update,
  input wire logic        o_soft_reset,
  input wire ncs_nv_req_t o_nv,
  input wire logic        i_nv_ack
);
  logic [2:0] pd;
  logic [2:0] wd3;
  logic       sel_q;
  logic       wen_q;
  logic       wr_pd;
  logic       wr_upd;
  logic       wr_rld;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Gathers the power-down outputs and the written low bits.
  assign pd = {o_input_loop_off, o_synth_loop_off, o_dist_off};
  assign wd3 = i_reg_wdata[2:0];
  // Decodes the host writes that the properties look at.
  assign wr_pd  = i_reg_wr && (i_reg_addr == ADDR_POWER_DOWN);
  assign wr_upd = i_reg_wr && (i_reg_addr == ADDR_APPLY_UPDATE)
                  && i_reg_wdata[0];
  assign wr_rld = i_reg_wr && (i_reg_addr == ADDR_CONTROL_ONE)
                  && i_reg_wdata[1];
  // Shadows the status select and write-enable bits from host writes.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      sel_q <= 1'b0;
      wen_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == ADDR_STATUS_PIN_CTL) begin
      sel_q <= i_reg_wdata[4];
    end else if (i_reg_wr && i_reg_addr == ADDR_CONTROL_ONE) begin
      wen_q <= i_reg_wdata[0];
    end
  end
  pd_reset_a: assert property ($rose(i_rst_b) |-> pd == 3'h7)
    else $error("power-down outputs not set after reset");
  pd_write_a: assert property (wr_pd |=> pd == $past(wd3))
    else $error("power-down write lost");
  pd_hold_a: assert property (!wr_pd |=> $stable(pd))
    else $error("power-down bits moved unasked");
  apply_once_a: assert property (o_apply_update |=> !o_apply_update)
    else $error("apply pulse longer than one cycle");
  update_sclk_a: assert property (
    wr_upd |-> ##[1:12] o_apply_update)
    else $error("update write gave no apply pulse");
  reload_boot_a: assert property (
    wr_rld && i_boot_sel |=> !o_soft_reset)
    else $error("reload taken with boot select high");
  protect_a: assert property (o_nv.req && o_nv.write |-> wen_q)
    else $error("store written while protected");
  status_mon_a: assert property (!sel_q |=>
    o_status_out_zero == $past(i_status_mon0))
    else $error("status output not following monitor");
  nv_hold_a: assert property (
    o_nv.req && !i_nv_ack |=> $stable(o_nv))
    else $error("store request changed before ack");
endmodule

bind ncs_config_store ncs_config_store_asserts u_chk (
  .i_core_clk        (i_core_clk),
  .i_rst_b           (i_rst_b),
  .i_reg_wr          (i_reg_wr),
  .i_reg_addr        (i_reg_addr),
  .i_reg_wdata       (i_reg_wdata),
  .i_boot_sel        (i_boot_sel),
  .i_status_mon0     (i_status_mon0),
  .o_status_out_zero (o_status_out_zero),
  .o_input_loop_off  (o_input_loop_off),
  .o_synth_loop_off  (o_synth_loop_off),
  .o_dist_off        (o_dist_off),
  .o_apply_update    (o_apply_update),
  .o_soft_reset      (o_soft_reset),
  .o_nv              (o_nv),
  .i_nv_ack          (i_nv_ack)
);

// file: verif/ncs_nv_model.sv
// Store and buffer bank model facing the block's store port.
// Assumes the core clock; ack delay and bad-data flag come from the bench.
`timescale 1ns/100ps
module ncs_nv_model
  import ncs_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_slow,
  input  wire logic         i_bad,
  input  wire ncs_nv_req_t  i_nv,
  input  wire ncs_buf_req_t i_buf,
  output logic              o_ack,
  output logic [7:0]        o_rdata,
  output logic              o_err,
  output logic [7:0]        o_buf_rdata
);
  logic [7:0] nv_mem [2048];
  logic [7:0] bank [4096];
  logic [7:0] rd_q;
  logic [7:0] junk = 8'h00;
  logic [1:0] dly = 2'h0;
  // Buffer bank starts with a pattern unlike its address.
  initial for (int i = 0; i < 4096; i++) bank[i] = 8'(i) ^ 8'hC3;
  // Acks after a short or long wait; read data churns outside the ack.
  always @(posedge i_core_clk) begin
    o_ack <= 1'b0;
    junk <= junk + 8'h3B;
    if (i_buf.we) bank[i_buf.addr] <= i_buf.data;
    if (i_nv.req && !o_ack) begin
      if (dly == (i_slow ? 2'h2 : 2'h0)) begin
        dly <= 2'h0;
        o_ack <= 1'b1;
        if (i_nv.write) nv_mem[i_nv.addr] <= i_nv.data;
        rd_q <= nv_mem[i_nv.addr];
      end else begin
        dly <= dly + 2'h1;
      end
    end
  end
  // Answer lines and the combinational bank read.
  assign o_rdata = o_ack ? rd_q : junk;
  assign o_err = o_ack & i_bad;
  assign o_buf_rdata = bank[i_buf.addr];
endmodule

// file: verif/tb.sv
// Self-checking bench for the configuration store block.
// Assumes the store model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb;
  import ncs_pkg::*;
  logic         i_core_clk = 1'b0;
  logic         i_rst_b = 1'b0;
  logic         i_sclk = 1'b0;
  logic         i_reg_wr = 1'b0;
  logic         i_reg_rd = 1'b0;
  logic [11:0]  i_reg_addr = 12'h000;
  logic [7:0]   i_reg_wdata = 8'h00;
  logic         i_boot_sel = 1'b0;
  logic         i_status_mon0 = 1'b0;
  logic         slow = 1'b0;
  logic         bad = 1'b0;
  logic         o_status_out_zero, o_input_loop_off, o_synth_loop_off;
  logic         o_dist_off, o_apply_update, o_soft_reset;
  logic         i_nv_ack, i_nv_err, rd_seen = 1'b0;
  logic [7:0]   o_reg_rdata, i_nv_rdata, i_buf_rdata, v;
  ncs_nv_req_t  o_nv;
  ncs_buf_req_t o_buf;
  logic [7:0]   expq [$];
  int           errors = 0, tests_run = 0, seed = 7640, n;
  int           apl_n = 0, srs_n = 0, nvw_n = 0;

  always #25 i_core_clk = ~i_core_clk;

  ncs_config_store dut (
    .i_core_clk        (i_core_clk),
    .i_rst_b           (i_rst_b),
    .i_sclk            (i_sclk),
    .i_reg_wr          (i_reg_wr),
    .i_reg_rd          (i_reg_rd),
    .i_reg_addr        (i_reg_addr),
    .i_reg_wdata       (i_reg_wdata),
    .o_reg_rdata       (o_reg_rdata),
    .i_boot_sel        (i_boot_sel),
    .i_status_mon0     (i_status_mon0),
    .o_status_out_zero (o_status_out_zero),
    .o_input_loop_off  (o_input_loop_off),
    .o_synth_loop_off  (o_synth_loop_off),
    .o_dist_off        (o_dist_off),
    .o_apply_update    (o_apply_update),
    .o_soft_reset      (o_soft_reset),
    .o_nv              (o_nv),
    .i_nv_ack          (i_nv_ack),
    .i_nv_rdata        (i_nv_rdata),
    .i_nv_err          (i_nv_err),
    .o_buf             (o_buf),
    .i_buf_rdata       (i_buf_rdata)
  );
  ncs_nv_model nvm (.i_core_clk(i_core_clk), .i_slow(slow), .i_bad(bad),
    .i_nv(o_nv), .i_buf(o_buf), .o_ack(i_nv_ack), .o_rdata(i_nv_rdata),
    .o_err(i_nv_err), .o_buf_rdata(i_buf_rdata));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge i_core_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    expq.push_back(e);
    @(negedge i_core_clk);
    i_reg_rd = 0;
  endtask

  task automatic xfer_wait();
    int k;
    repeat (4) @(negedge i_core_clk);
    for (k = 0; k < 9000 && o_status_out_zero === 1'b1; k++)
      @(negedge i_core_clk);
    if (k == 9000) begin
      errors++;
      $display("transfer still busy at %0t", $time);
    end
  endtask

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compares each read answer with the oldest note and counts events.
  always @(posedge i_core_clk) begin
    if (rd_seen) chk(o_reg_rdata, expq.pop_front());
    rd_seen <= i_reg_rd;
    if (o_apply_update) apl_n++;
    if (o_soft_reset) srs_n++;
    if (o_nv.req && o_nv.write && i_nv_ack) nvw_n++;
  end

  // Serial clock runs free at an eighth of the core rate.
  always begin
    repeat (4) @(negedge i_core_clk);
    i_sclk = ~i_sclk;
    i_status_mon0 = 1'($random(seed));
  end

  // Main sequence.
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    rd(ADDR_POWER_DOWN, 8'h07);
    rd(ADDR_CONTROL_ONE, 8'h00);
    rd(12'h100, 8'h00);
    for (int i = 0; i < SEG_COUNT; i++)
      rd(ADDR_SEG_FIRST + 12'(i), SEG_DEFAULT[i]);
    repeat (3) begin
      v = 8'($random(seed));
      wr(ADDR_POWER_DOWN, v);
      rd(ADDR_POWER_DOWN, {5'h00, v[2:0]});
      chk({5'h00, o_input_loop_off, o_synth_loop_off, o_dist_off},
          {5'h00, v[2:0]});
    end
    n = apl_n;
    wr(ADDR_APPLY_UPDATE, 8'h01);
    repeat (30) @(negedge i_core_clk);
    chk(8'(apl_n - n), 8'h01);
    wr(ADDR_STATUS_PIN_CTL, 8'h10);
    wr(ADDR_CONTROL_TWO, 8'h01);
    repeat (10) @(negedge i_core_clk);
    rd(ADDR_XFER_STATUS, 8'h00);
    chk(8'(nvw_n), 8'h00);
    // Default table store with a slow store.
    slow = 1'b1;
    n = apl_n;
    wr(ADDR_CONTROL_ONE, 8'h01);
    wr(ADDR_CONTROL_TWO, 8'h01);
    rd(ADDR_XFER_STATUS, 8'h01);
    rd(ADDR_CONTROL_TWO, 8'h01);
    chk({7'h00, o_status_out_zero}, 8'h01);
    xfer_wait();
    rd(ADDR_XFER_STATUS, 8'h00);
    rd(ADDR_CONTROL_TWO, 8'h00);
    rd(ADDR_ERROR_READBACK, 8'h00);
    chk(8'(apl_n - n), 8'h01);
    chk(nvm.nv_mem[130], nvm.bank[12'h102]);
    chk(nvm.nv_mem[383], nvm.bank[12'h27F]);
    // Short table of one two-byte range and no update code.
    slow = 1'b0;
    wr(ADDR_SEG_FIRST, 8'h01);
    wr(ADDR_SEG_FIRST + 12'h001, 8'h02);
    wr(ADDR_SEG_FIRST + 12'h002, 8'h34);
    wr(ADDR_SEG_FIRST + 12'h003, 8'hFF);
    rd(ADDR_SEG_FIRST + 12'h002, 8'h34);
    n = apl_n;
    wr(ADDR_CONTROL_TWO, 8'h01);
    xfer_wait();
    chk(nvm.nv_mem[1], nvm.bank[12'h235]);
    chk(8'(apl_n - n), 8'h00);
    // Reload with bad data, then a refused reload.
    v = nvm.bank[12'h234];
    nvm.bank[12'h234] = ~v;
    n = srs_n;
    bad = 1'b1;
    wr(ADDR_CONTROL_ONE, 8'h03);
    xfer_wait();
    chk(nvm.bank[12'h234], v);
    rd(ADDR_CONTROL_ONE, 8'h01);
    rd(ADDR_ERROR_READBACK, 8'h01);
    bad = 1'b0;
    i_boot_sel = 1'b1;
    wr(ADDR_CONTROL_ONE, 8'h03);
    repeat (10) @(negedge i_core_clk);
    chk(8'(srs_n - n), 8'h01);
    rd(ADDR_XFER_STATUS, 8'h00);
    tally_and_finish();
  end

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge i_core_clk);
    errors++;
    tally_and_finish();
  end
endmodule
